//--- dtmf_status_pkg.sv
// Constants and types shared by the tone and status word builder.
`default_nettype none
package dtmf_status_pkg;
   // Positions of the two words inside the 24-word output packet
   localparam int TONE_WORD_INDEX = 10;
   localparam int STATUS_WORD_INDEX = 11;

   // Tone identification codes
   localparam logic [7:0] CODE_KEYPAD_BASE = 8'h80;
   localparam logic [7:0] CODE_DIAL = 8'h90;
   localparam logic [7:0] CODE_RING = 8'h91;
   localparam logic [7:0] CODE_BUSY = 8'h92;
   localparam logic [7:0] CODE_NONE = 8'hff;

   // Candidate index: row*4+col for keypad, then call-progress tones
   localparam int TONE_IDX_W = 5;
   localparam logic [4:0] IDX_KEYPAD_LAST = 5'h0f;
   localparam logic [4:0] IDX_DIAL = 5'h10;
   localparam logic [4:0] IDX_RING = 5'h11;
   localparam logic [4:0] IDX_BUSY = 5'h12;

   // Amplitude range in dBm0
   localparam logic signed [7:0] AMP_MAX = 8'sh03;
   localparam logic signed [7:0] AMP_MIN = 8'shc4;

   // Acceptance thresholds; deviations are in tenths of a percent
   localparam logic signed [7:0] LEVEL_MIN_DBM0 = 8'she7;
   localparam logic [7:0] SNR_MIN_DB = 8'h0f;
   localparam logic [7:0] DEV_PASS = 8'h0f;
   localparam logic [7:0] DEV_MAX = 8'h23;
   localparam logic signed [7:0] TWIST_NORMAL_PASS_DB = 8'sh08;
   localparam logic signed [7:0] TWIST_REVERSE_PASS_DB = 8'sh04;
   localparam logic signed [7:0] TWIST_MAX_DB = 8'sh0a;
   localparam logic [15:0] MIN_DURATION_MS = 16'h002d;
   localparam logic [7:0] ENVELOPE_DROP_DB = 8'h14;

   // Tone word and status word fields
   localparam int AMP_MSB = 15;
   localparam int AMP_LSB = 8;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 0;
   localparam int VOL_MSB = 15;
   localparam int VOL_LSB = 8;
   localparam int SLEEP_BIT = 3;
   localparam int ECHO_BIT = 2;
   localparam int RATE_MSB = 1;
   localparam int RATE_LSB = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   typedef enum logic [1:0] {
      RATE_BOTH = 2'h0,
      RATE_ENC_ONLY = 2'h1,
      RATE_DEC_ONLY = 2'h2,
      RATE_NEITHER = 2'h3
   } rate_sel_t;

   typedef enum logic [1:0] {
      HOLD_IDLE = 2'b00,
      HOLD_FIRST = 2'b01,
      HOLD_REPEAT = 2'b11
   } hold_t;

   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TONE_WORD = 8'h04;
   localparam logic [7:0] ADDR_STATUS_WORD = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // Interrupt bits
   localparam int IRQ_W = 2;
   localparam int IRQ_TONE = 0;
   localparam int IRQ_FRAME = 1;
endpackage : dtmf_status_pkg
`default_nettype wire

//--- tone_code_rom.sv
// Registered lookup from candidate tone index to tone code.
`default_nettype none
module tone_code_rom
   import dtmf_status_pkg::*;
(
   input wire logic clk,                   // Clock
   input wire logic rst,                   // Async reset, high
   input wire logic [TONE_IDX_W-1:0] idx,  // Candidate index
   output logic [7:0] code_q               // Code, one cycle later
);
   logic [7:0] code_d;

   always_comb begin
      code_d = CODE_NONE;
      if (idx <= IDX_KEYPAD_LAST) begin
         // Keypad code carries column in bits 3:2 and row in bits 1:0
         code_d = CODE_KEYPAD_BASE | {4'h0, idx[1:0], idx[3:2]};
      end else if (idx == IDX_DIAL) begin
         code_d = CODE_DIAL;
      end else if (idx == IDX_RING) begin
         code_d = CODE_RING;
      end else if (idx == IDX_BUSY) begin
         code_d = CODE_BUSY;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_q <= CODE_NONE;
      end else begin
         code_q <= code_d;
      end
   end
endmodule : tone_code_rom
`default_nettype wire

//--- dtmf_status_word_builder.sv
// Builds the tone detection word and the control status word per frame.
//
// Function
// - Word 10: amplitude high byte, code low
// - Keypad tones coded 0x80 to 0x8f
// - Dial, ring, busy have own codes
// - No tone gives code byte all ones
// - Amplitude signed byte, plus three to minus sixty
// - Level above minus 25 not rejected
// - Signal to noise must exceed 15 dB
// - Deviation within 1.5 percent accepted
// - Deviation beyond 3.5 percent rejected
// - Normal twist: reject above 10 dB
// - Reverse twist: reject above 10 dB
// - Tones longer than 45 ms accepted; the code uses MIN_DURATION, 45 by default
// - Valid tone reported in two frames
// - Word 11 layout: volume, zeros, flags, rate
// - Rate selector shows where rates applied
// - Echo cancel bit set when enabled
// - Sleep bit set in sleep mode
// - Volume field shows current volume
`default_nettype none
module dtmf_status_word_builder
   import dtmf_status_pkg::*;
#(
   parameter logic [7:0] DEV_LIMIT = DEV_MAX,
   parameter logic signed [7:0] NORMAL_TWIST_LIMIT = TWIST_MAX_DB,
   parameter logic signed [7:0] REVERSE_TWIST_LIMIT = TWIST_MAX_DB,
   parameter logic [15:0] MIN_DURATION = MIN_DURATION_MS
) (
   input wire logic clk,                       // 250 MHz clock
   input wire logic rst,                       // Async reset, high
   input wire logic frame_valid,               // One pulse per frame
   input wire logic cand_valid,                // A candidate was seen
   input wire logic [TONE_IDX_W-1:0] cand_idx, // Candidate tone index
   input wire logic signed [7:0] level_dbm0,   // Candidate level
   input wire logic [7:0] snr_db,              // In-band over out-band
   input wire logic [7:0] low_dev,             // Low tone deviation
   input wire logic [7:0] high_dev,            // High tone deviation
   input wire logic signed [7:0] twist_db,     // Low minus high energy
   input wire logic [15:0] duration_ms,        // Measured duration
   input wire logic [ADDR_W-1:0] addr,         // Register address
   input wire logic [31:0] wr_data,            // Register write data
   input wire logic wr_en,                     // Write strobe
   input wire logic rd_en,                     // Read strobe
   output logic [31:0] rd_data_q,              // Read data
   output logic [15:0] tone_word_q,            // Packet word 10
   output logic [15:0] status_word_q,          // Packet word 11
   output logic words_valid_q,                 // Words refreshed
   output logic irq_q                          // Interrupt level
);
   // Gray zone between sure-pass and sure-reject is set by parameter
   localparam logic [7:0] DEV_LIM = (DEV_LIMIT < DEV_PASS) ? DEV_PASS :
      ((DEV_LIMIT > DEV_MAX) ? DEV_MAX : DEV_LIMIT);
   localparam logic signed [7:0] NTW_LIM =
      (NORMAL_TWIST_LIMIT < TWIST_NORMAL_PASS_DB) ? TWIST_NORMAL_PASS_DB :
      ((NORMAL_TWIST_LIMIT > TWIST_MAX_DB) ? TWIST_MAX_DB :
      NORMAL_TWIST_LIMIT);
   localparam logic signed [7:0] RTW_LIM =
      (REVERSE_TWIST_LIMIT < TWIST_REVERSE_PASS_DB) ? TWIST_REVERSE_PASS_DB
      : ((REVERSE_TWIST_LIMIT > TWIST_MAX_DB) ? TWIST_MAX_DB :
      REVERSE_TWIST_LIMIT);
   localparam logic signed [7:0] RTW_NEG = -RTW_LIM;

   function automatic logic [7:0] clamp_amp(input logic signed [7:0] v);
      logic [7:0] r;
      r = v;
      if (v > AMP_MAX) begin
         r = AMP_MAX;
      end else if (v < AMP_MIN) begin
         r = AMP_MIN;
      end
      return r;
   endfunction : clamp_amp

   // Both tones share one deviation test
   function automatic logic dev_ok(input logic [7:0] dev);
      return dev <= DEV_LIM;
   endfunction : dev_ok

   // Write decode shared by every writable register
   function automatic logic reg_hit(input logic en,
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
      return en && (a == target);
   endfunction : reg_hit

   logic [7:0] rom_code;
   logic accept;

   // Frame taken at edge c0; lookup and verdict meet at c1; words and
   // their pulse leave at c2, so the host sees a fixed latency
   // Stage 1: acceptance test, registered beside the code lookup
   logic s1_valid_q, s1_valid_d;
   logic s1_accept_q, s1_accept_d;
   logic [7:0] s1_amp_q, s1_amp_d;

   // Stage 2: hold machine and packet words
   hold_t hold_q, hold_d;
   logic [7:0] held_code_q, held_code_d;
   logic [7:0] held_amp_q, held_amp_d;
   logic [15:0] tone_word_d;
   logic [15:0] status_word_d;
   logic words_valid_d;

   // Registers
   logic [15:0] ctrl_q, ctrl_d;
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
   logic [IRQ_W-1:0] irq_set;
   logic [31:0] rd_data_d;
   logic irq_d;

   tone_code_rom tone_code_rom_inst (
      .clk(clk),
      .rst(rst),
      .idx(cand_idx),
      .code_q(rom_code)
   );

   always_comb begin
      accept = cand_valid && (cand_idx <= IDX_BUSY);
      accept = accept && (level_dbm0 > LEVEL_MIN_DBM0);
      accept = accept && (snr_db > SNR_MIN_DB);
      // Limit sits between the 1.5 and 3.5 percent bounds
      accept = accept && dev_ok(low_dev);
      accept = accept && dev_ok(high_dev);
      accept = accept && (twist_db <= NTW_LIM);
      accept = accept && (twist_db >= RTW_NEG);
      accept = accept && (duration_ms > MIN_DURATION);
   end

   always_comb begin
      s1_valid_d = frame_valid;
      s1_accept_d = frame_valid && accept;
      s1_amp_d = clamp_amp(level_dbm0);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_valid_q <= 1'b0;
         s1_accept_q <= 1'b0;
         s1_amp_q <= 8'h00;
      end else begin
         s1_valid_q <= s1_valid_d;
         s1_accept_q <= s1_accept_d;
         s1_amp_q <= s1_amp_d;
      end
   end

   always_comb begin
      hold_d = hold_q;
      held_code_d = held_code_q;
      held_amp_d = held_amp_q;
      tone_word_d = tone_word_q;
      words_valid_d = 1'b0;
      if (s1_valid_q) begin
         words_valid_d = 1'b1;
         if (s1_accept_q) begin
            hold_d = HOLD_FIRST;
            held_code_d = rom_code;
            held_amp_d = s1_amp_q;
            tone_word_d[AMP_MSB:AMP_LSB] = s1_amp_q;
            tone_word_d[CODE_MSB:CODE_LSB] = rom_code;
         end else begin
            unique case (hold_q)
               HOLD_FIRST: begin
                  // A lone detection still goes out in a second frame
                  hold_d = HOLD_REPEAT;
                  tone_word_d[AMP_MSB:AMP_LSB] = held_amp_q;
                  tone_word_d[CODE_MSB:CODE_LSB] = held_code_q;
               end
               HOLD_REPEAT, HOLD_IDLE: begin
                  hold_d = HOLD_IDLE;
                  tone_word_d[AMP_MSB:AMP_LSB] = 8'h00;
                  tone_word_d[CODE_MSB:CODE_LSB] = CODE_NONE;
               end
               default: begin
                  hold_d = HOLD_IDLE;
                  tone_word_d[AMP_MSB:AMP_LSB] = 8'h00;
                  tone_word_d[CODE_MSB:CODE_LSB] = CODE_NONE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= HOLD_IDLE;
         held_code_q <= CODE_NONE;
         held_amp_q <= 8'h00;
         tone_word_q <= {8'h00, CODE_NONE};
         words_valid_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
         held_code_q <= held_code_d;
         held_amp_q <= held_amp_d;
         tone_word_q <= tone_word_d;
         words_valid_q <= words_valid_d;
      end
   end

   // Control state in effect at the frame; unused bits stay zero
   always_comb begin
      status_word_d = status_word_q;
      if (s1_valid_q) begin
         status_word_d = '0;
         status_word_d[VOL_MSB:VOL_LSB] =
            ctrl_q[VOL_MSB:VOL_LSB];
         status_word_d[SLEEP_BIT] = ctrl_q[SLEEP_BIT];
         status_word_d[ECHO_BIT] = ctrl_q[ECHO_BIT];
         status_word_d[RATE_MSB:RATE_LSB] =
            ctrl_q[RATE_MSB:RATE_LSB];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_word_q <= 16'h0000;
      end else begin
         status_word_q <= status_word_d;
      end
   end

   // Register file: control, interrupt and read groups
   // Control register keeps only the word 11 fields
   always_comb begin
      ctrl_d = ctrl_q;
      if (reg_hit(wr_en, addr, ADDR_CTRL)) begin
         ctrl_d = CTRL_RESET;
         ctrl_d[VOL_MSB:VOL_LSB] = wr_data[VOL_MSB:VOL_LSB];
         ctrl_d[SLEEP_BIT] = wr_data[SLEEP_BIT];
         ctrl_d[ECHO_BIT] = wr_data[ECHO_BIT];
         ctrl_d[RATE_MSB:RATE_LSB] = wr_data[RATE_MSB:RATE_LSB];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Sticky interrupt status, mask and level output
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_TONE] = s1_valid_q && s1_accept_q && (hold_q == HOLD_IDLE);
      irq_set[IRQ_FRAME] = s1_valid_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      if (reg_hit(wr_en, addr, ADDR_IRQ_MASK)) begin
         irq_mask_d = wr_data[IRQ_W-1:0];
      end
      if (reg_hit(wr_en, addr, ADDR_IRQ_STATUS)) begin
         irq_stat_d = irq_stat_q & ~wr_data[IRQ_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      irq_stat_d = irq_stat_d | irq_set;
      // Taken from the next status so the level has no extra lag
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask_q <= '0;
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         irq_q <= irq_d;
      end
   end

   // Read data stand for the one cycle after the strobe, zero otherwise
   always_comb begin
      rd_data_d = 32'h0000_0000;
      if (rd_en) begin
         unique case (addr)
            ADDR_CTRL: rd_data_d = {16'h0000, ctrl_q};
            ADDR_TONE_WORD: rd_data_d = {16'h0000, tone_word_q};
            ADDR_STATUS_WORD: rd_data_d = {16'h0000, status_word_q};
            ADDR_IRQ_STATUS: rd_data_d = {30'h0, irq_stat_q};
            ADDR_IRQ_MASK: rd_data_d = {30'h0, irq_mask_q};
            default: rd_data_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= 32'h0000_0000;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end
endmodule : dtmf_status_word_builder
`default_nettype wire

//--- tone_word_checker_properties.sv
// Checker for the tone and status word builder, bound to its top.
`default_nettype none
module tone_word_checker
   import dtmf_status_pkg::*;
#(
   parameter logic [7:0] DEV_LIMIT = DEV_MAX,
   parameter logic signed [7:0] NORMAL_TWIST_LIMIT = TWIST_MAX_DB,
   parameter logic signed [7:0] REVERSE_TWIST_LIMIT = TWIST_MAX_DB,
   parameter logic [15:0] MIN_DURATION = MIN_DURATION_MS
) (
   input wire logic clk,                       // Clock
   input wire logic rst,                       // Reset
   input wire logic frame_valid,               // Frame pulse
   input wire logic cand_valid,                // Candidate seen
   input wire logic [TONE_IDX_W-1:0] cand_idx, // Candidate index
   input wire logic signed [7:0] level_dbm0,   // Level
   input wire logic [7:0] snr_db,              // Signal to noise
   input wire logic [7:0] low_dev,             // Low deviation
   input wire logic [7:0] high_dev,            // High deviation
   input wire logic signed [7:0] twist_db,     // Twist
   input wire logic [15:0] duration_ms,        // Duration
   input wire logic [15:0] tone_word_q,        // Word 10
   input wire logic [15:0] status_word_q,      // Word 11
   input wire logic words_valid_q,             // Refresh pulse
   input wire logic irq_q                      // Interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] code;
   logic signed [7:0] amp;
   logic bad;
   logic good;
   assign code = tone_word_q[7:0];
   assign amp = tone_word_q[15:8];
   // Any one failed criterion rejects the candidate
   assign bad = !cand_valid || cand_idx > 5'd18 ||
      level_dbm0 <= LEVEL_MIN_DBM0 || snr_db <= SNR_MIN_DB ||
      low_dev > DEV_LIMIT || high_dev > DEV_LIMIT ||
      twist_db > NORMAL_TWIST_LIMIT || twist_db < -REVERSE_TWIST_LIMIT ||
      duration_ms <= MIN_DURATION;
   // Clearly inside every pass band
   assign good = cand_valid && cand_idx <= 5'd18 &&
      level_dbm0 > LEVEL_MIN_DBM0 && snr_db > SNR_MIN_DB &&
      low_dev <= DEV_PASS && high_dev <= DEV_PASS &&
      twist_db < TWIST_NORMAL_PASS_DB && twist_db > -TWIST_REVERSE_PASS_DB &&
      duration_ms > MIN_DURATION;
   words_latency_a:
      assert property (frame_valid |-> ##2 words_valid_q)
      else $error("words not refreshed two cycles after frame");
   words_cause_a:
      assert property (words_valid_q |-> $past(frame_valid, 2))
      else $error("refresh pulse without frame");
   words_hold_a:
      assert property (!words_valid_q |->
         $stable(tone_word_q) && $stable(status_word_q))
      else $error("words changed between frames");
   status_zero_a:
      assert property (status_word_q[7:4] == 4'h0)
      else $error("unused status bits not zero");
   no_tone_a:
      assert property (code == CODE_NONE |-> amp == 8'sh00)
      else $error("no tone word has amplitude");
   code_set_a:
      assert property (code == CODE_NONE ||
         (code >= CODE_KEYPAD_BASE && code <= CODE_BUSY))
      else $error("tone code outside table");
   amp_range_a:
      assert property (code != CODE_NONE |-> amp <= AMP_MAX && amp >= AMP_MIN)
      else $error("amplitude outside range");
   reject_frame_a:
      assert property (frame_valid && bad |->
         ##2 (code == CODE_NONE || $stable(tone_word_q)))
      else $error("rejected candidate reported as new tone");
   accept_frame_a:
      assert property (frame_valid && good |-> ##2 code != CODE_NONE)
      else $error("valid candidate not reported");
   accept_c: cover property (frame_valid && good);
   repeat_c: cover property (frame_valid && bad ##2 code != CODE_NONE);
   irq_c: cover property ($rose(irq_q));
endmodule : tone_word_checker
bind dtmf_status_word_builder tone_word_checker #(
   .DEV_LIMIT(DEV_LIMIT), .NORMAL_TWIST_LIMIT(NORMAL_TWIST_LIMIT),
   .REVERSE_TWIST_LIMIT(REVERSE_TWIST_LIMIT), .MIN_DURATION(MIN_DURATION)
) checker_inst (.clk, .rst, .frame_valid, .cand_valid, .cand_idx,
   .level_dbm0, .snr_db, .low_dev, .high_dev, .twist_db, .duration_ms,
   .tone_word_q, .status_word_q, .words_valid_q, .irq_q);
`default_nettype wire

//--- host_packet_reader.sv
// Host side model: takes words 10 and 11 of each output packet.
`default_nettype none
module host_packet_reader (
   input wire logic clk,                // Clock
   input wire logic rst,                // Reset
   input wire logic words_valid_q,      // Refresh pulse
   input wire logic [15:0] tone_word_q, // Word 10
   input wire logic [15:0] status_word_q, // Word 11
   output logic got_q,                  // Packet taken
   output logic [15:0] tone_q,          // Captured word 10
   output logic [15:0] stat_q           // Captured word 11
);
   logic got_d;
   logic [15:0] tone_d;
   logic [15:0] stat_d;
   always_comb begin
      got_d = words_valid_q;
      tone_d = words_valid_q ? tone_word_q : tone_q;
      stat_d = words_valid_q ? status_word_q : stat_q;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         got_q <= 1'b0;
         tone_q <= 16'h0000;
         stat_q <= 16'h0000;
      end else begin
         got_q <= got_d;
         tone_q <= tone_d;
         stat_q <= stat_d;
      end
   end
endmodule : host_packet_reader
`default_nettype wire

//--- dtmf_status_word_builder_test.sv
// Self-checking bench for the tone and status word builder.
`default_nettype none
module dtmf_status_word_builder_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dtmf_status_pkg::*;
   logic clk = 0, rst = 1, frame_valid = 0, cand_valid = 0;
   logic wr_en = 0, rd_en = 0, rd_d = 0, words_valid_q, irq_q, got_q;
   logic [4:0] cand_idx = '0, idx;
   logic signed [7:0] level_dbm0 = '0, twist_db = '0, lvl;
   logic [7:0] snr_db = '0, low_dev = '0, high_dev = '0, addr = '0;
   logic [15:0] duration_ms = '0, ctrl = '0, t_exp, got_t, got_s;
   logic [15:0] tone_word_q, status_word_q;
   logic [31:0] wr_data = '0, rd_data_q, rq[$], wq[$];
   int fail_count = 0, num_checks = 0;
   dtmf_status_word_builder dtmf_status_word_builder_inst (.clk, .rst,
      .frame_valid, .cand_valid, .cand_idx, .level_dbm0, .snr_db, .low_dev,
      .high_dev, .twist_db, .duration_ms, .addr, .wr_data, .wr_en, .rd_en,
      .rd_data_q, .tone_word_q, .status_word_q, .words_valid_q, .irq_q);
   host_packet_reader host_packet_reader_inst (.clk, .rst, .words_valid_q,
      .tone_word_q, .status_word_q, .got_q, .tone_q(got_t), .stat_q(got_s));
   always #2 clk = ~clk;
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      rd_en <= 1'b0;
   endtask : rd
   // Measurements: k below zero passes, k 0..8 breaks one criterion
   task automatic meas(input int k);
      cand_valid <= (k != 0);
      cand_idx <= (k == 1) ? 5'h13 : idx;
      level_dbm0 <= (k == 2) ? -8'sd25 : lvl;
      snr_db <= (k == 3) ? 8'h0f : 8'h10 + 8'($urandom_range(239));
      low_dev <= (k == 4) ? 8'h24 : 8'($urandom_range(35));
      high_dev <= (k == 5) ? 8'h24 : 8'($urandom_range(35));
      twist_db <= (k == 6) ? 8'sh0b : (k == 7) ? -8'sd11 :
         8'($urandom_range(20)) - 8'sd10;
      duration_ms <= (k == 8) ? 16'h002d : 16'h002e + 16'($urandom_range(900));
   endtask : meas
   task automatic send(input logic [15:0] t);
      @(posedge clk);
      frame_valid <= 1'b1;
      wq.push_back({t, ctrl[15:8], 4'h0, ctrl[3:0]});
      @(posedge clk);
      frame_valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : send
   // Tone codes by row*4+col, then dial, ring and busy
   function automatic logic [7:0] code_of(input logic [4:0] x);
      logic [7:0] tbl [19] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h81, 8'h85,
         8'h89, 8'h8d, 8'h82, 8'h86, 8'h8a, 8'h8e, 8'h83, 8'h87, 8'h8b,
         8'h8f, 8'h90, 8'h91, 8'h92};
      return tbl[x];
   endfunction : code_of
   always @(posedge clk) rd_d <= rd_en;
   always @(negedge clk) begin
      if (rd_d) begin
         if (rq.size() == 0) chk(1'b0, "unexpected read");
         else chk(rd_data_q === rq.pop_front(), "read data");
      end else if (rd_data_q !== 32'h0) begin
         chk(1'b0, "read data outside its cycle");
      end
      if (got_q) begin
         if (wq.size() == 0) chk(1'b0, "unexpected packet");
         else chk({got_t, got_s} === wq.pop_front(), "packet words");
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      chk(1'b0, "timeout");
      conclude();
   end
   initial begin
      void'($urandom(94610));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_TONE_WORD, 32'h0000_00ff);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(ADDR_STATUS_WORD, 32'h0);
      rd(ADDR_IRQ_STATUS, 32'h0);
      rd(8'h14, 32'h0);
      $display("Test reset values done");
      for (int i = 0; i < 19; i++) begin
         ctrl = 16'($urandom) & 16'hff0f;
         wr(ADDR_CTRL, {16'h0, ctrl} | 32'h00f0);
         rd(ADDR_CTRL, {16'h0, ctrl});
         idx = 5'(i);
         lvl = -8'sd24 + 8'($urandom_range(151));
         t_exp = {(lvl > AMP_MAX) ? AMP_MAX : lvl, code_of(idx)};
         meas(-1);
         send(t_exp);
         rd(ADDR_TONE_WORD, {16'h0, t_exp});
         rd(ADDR_STATUS_WORD, {16'h0, ctrl});
         meas(i % 9);
         send(t_exp);
         meas((i + 4) % 9);
         send(16'h00ff);
      end
      $display("Test tone codes done");
      wr(ADDR_IRQ_STATUS, 32'h3);
      rd(ADDR_IRQ_STATUS, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h3);
      rd(ADDR_IRQ_MASK, 32'h3);
      chk(irq_q === 1'b0, "irq high with status clear");
      meas(-1);
      send(t_exp);
      chk(irq_q === 1'b1, "irq not raised");
      rd(ADDR_IRQ_STATUS, 32'h3);
      wr(ADDR_IRQ_STATUS, 32'h3);
      repeat (3) @(posedge clk);
      chk(irq_q === 1'b0, "irq not cleared");
      wr(ADDR_IRQ_MASK, 32'h0);
      meas(0);
      send(t_exp);
      chk(irq_q === 1'b0, "masked irq raised");
      rd(ADDR_IRQ_STATUS, 32'h2);
      wr(ADDR_IRQ_MASK, 32'h2);
      repeat (3) @(posedge clk);
      chk(irq_q === 1'b1, "unmasked irq low");
      $display("Test interrupts done");
      repeat (5) @(posedge clk);
      chk(wq.size() == 0 && rq.size() == 0, "results missing");
      conclude();
   end
endmodule : dtmf_status_word_builder_test
`default_nettype wire
